// ### rtl/spdp_packer.sv
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Functional notes
// - Accept at most the configured host count.
// - Bypass on: skip only unresponsive hosts.
// - Bypass off: any jam on an active host halts all.
// - Multi-host driver commands need permission.
// - Release packet when length threshold reached.
// - Zero threshold means pack on full only.
// - Two delimiters, each with enable.
// - Delimiter pattern received releases the packet.
// - Both enabled: first then second adjacent.
// - Full buffer always releases a packet.
// - Delimiter handling: keep, plus one/two, strip.
// - Idle gap in ms packs; zero disables.
module spdp_packer #(
  parameter int unsigned MS_CYCLES  = spdp_pkg::SPDP_MS_CYCLES,
  parameter int unsigned FIFO_DEPTH = spdp_pkg::SPDP_FIFO_DEP,
  parameter logic [10:0] BUF_BYTES  = spdp_pkg::SPDP_BUF_RST
) (
  // Clock and reset.
  input  wire logic             mclk_i,
  input  wire logic             rstn_i,
  // Register port.
  input  wire logic [4:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic [31:0]           reg_rdata_o,
  // Serial byte stream in.
  input  wire logic             rx_valid_i,
  input  wire logic [7:0]       rx_data_i,
  output logic                  rx_ready_o,
  // Packet stream out.
  output logic                  pkt_valid_o,
  input  wire logic             pkt_ready_i,
  output spdp_pkg::spdp_word_t  pkt_word_o,
  // Host connections.
  input  wire logic             conn_req_i,
  output logic                  conn_grant_o,
  output logic                  conn_deny_o,
  output logic [1:0]            conn_slot_o,
  input  wire logic [3:0]       conn_close_i,
  input  wire logic [3:0]       host_jam_i,
  output logic [3:0]            tx_en_o,
  // Driver control commands.
  input  wire logic             drv_cmd_i,
  output logic                  drv_ack_o
);
  import spdp_pkg::*;

  // ==========================================================
  // Configuration registers.
  logic [2:0]  max_q;    // Host limit, 1 to 4.
  logic        byp_q;    // Skip unresponsive hosts.
  logic        drv_q;    // Driver commands allowed.
  logic [10:0] len_q;    // Length threshold.
  spdp_dlm_t   dlm_q;    // Delimiter characters.
  spdp_proc_t  proc_q;   // Delimiter handling.
  logic [15:0] gap_q;    // Idle gap in ms.
  logic [31:0] rdata_q;  // Read data register.

  // Clamp writes into the documented ranges.
  wire [2:0]  wmax_w = reg_wdata_i[SPDP_MAX_LSB +: 3];
  wire [2:0]  max_w  = (wmax_w == 3'h0) ? SPDP_MAX_RST :
                       (wmax_w > SPDP_MAX_TOP) ? SPDP_MAX_TOP : wmax_w;
  wire [10:0] len_w  = (reg_wdata_i[15:0] > {5'h00, SPDP_LEN_TOP}) ?
                       SPDP_LEN_TOP : reg_wdata_i[10:0];

  // Register writes; unmapped offsets are ignored.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      max_q  <= SPDP_MAX_RST;
      byp_q  <= SPDP_BYP_RST;
      drv_q  <= SPDP_DRV_RST;
      len_q  <= SPDP_LEN_RST;
      dlm_q  <= SPDP_DLM_RST;
      proc_q <= PROC_NONE;
      gap_q  <= SPDP_GAP_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        // Connection limits and policy.
        SPDP_OFF_CONN: begin
          max_q <= max_w;
          byp_q <= reg_wdata_i[SPDP_BYP_BIT];
          drv_q <= reg_wdata_i[SPDP_DRV_BIT];
        end
        SPDP_OFF_LEN: len_q <= len_w;
        SPDP_OFF_DLM: begin
          dlm_q  <= reg_wdata_i[SPDP_DLM_LSB +: 18];
          proc_q <= spdp_proc_t'(reg_wdata_i[SPDP_PROC_LSB +: 2]);
        end
        SPDP_OFF_GAP: gap_q <= reg_wdata_i[15:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Host connection slots.
  logic [3:0] act_q;      // Slots in use.
  logic [3:0] gmask;      // Slot picked for a grant.
  logic [1:0] gslot;      // Index of that slot.
  wire  [2:0] nact_w = 3'($countones(act_q));
  wire        room_w = (nact_w < max_q) && (act_q != 4'hf);
  wire        grant_w = conn_req_i & room_w;
  wire        halt_w;

  // Lowest free slot wins.
  always_comb begin
    gmask = 4'h0;
    gslot = 2'h0;
    for (int i = SPDP_HOSTS - 1; i >= 0; i--) begin
      if (!act_q[i]) begin
        gmask = 4'h1 << i;
        gslot = 2'(i);
      end
    end
  end

  // A grant only takes a free slot, so it never meets a close.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act_q        <= 4'h0;
      conn_grant_o <= 1'b0;
      conn_deny_o  <= 1'b0;
      conn_slot_o  <= 2'h0;
      drv_ack_o    <= 1'b0;
    end else begin
      act_q        <= (act_q & ~conn_close_i) | (grant_w ? gmask : 4'h0);
      conn_grant_o <= grant_w;
      conn_deny_o  <= conn_req_i & ~room_w;
      conn_slot_o  <= grant_w ? gslot : conn_slot_o;
      drv_ack_o    <= drv_cmd_i & ((max_q == 3'h1) | drv_q);
    end
  end

  // Hosts that may be sent to right now.
  wire [3:0] jam_w = act_q & host_jam_i;
  assign tx_en_o = (byp_q || jam_w == 4'h0) ? (act_q & ~host_jam_i) : 4'h0;
  assign halt_w  = (tx_en_o == 4'h0);

  // ==========================================================
  // Packing engine.
  logic [10:0] cnt_q;      // Bytes in the current packet.
  logic        seen_q;     // First of a pair seen.
  logic [1:0]  wait_q;     // Trailing bytes still owed.
  logic [15:0] gcnt_q;     // Milliseconds since last byte.
  logic        seen_d;
  logic [1:0]  wait_d;
  spdp_word_t  word_d;     // Word offered to the FIFO.
  logic        fifo_rdy;
  logic        ms_tick;

  wire        pair_w   = dlm_q.en1 & dlm_q.en2;
  wire        single_w = dlm_q.en1 & ~dlm_q.en2;
  wire        strip_w  = (proc_q == PROC_STRIP);
  wire [10:0] cinc_w   = cnt_q + 11'h001;
  wire        cap_w    = ((len_q != 11'h000) && (cinc_w == len_q)) ||
                         (cinc_w == BUF_BYTES);
  wire        match_w  = (wait_q == 2'h0) &&
                         (pair_w ? (seen_q && rx_data_i == dlm_q.d2) :
                          (single_w && rx_data_i == dlm_q.d1));
  // A stripped first character that turned out not to start a pair.
  wire        flush_w  = seen_q & strip_w & rx_valid_i & ~match_w;
  // The first of a pair is held back while stripping.
  wire        hold_w   = rx_valid_i & strip_w & pair_w & (wait_q == 2'h0) &
                         ~seen_q & (rx_data_i == dlm_q.d1);
  wire        data_w   = (cnt_q != 11'h000) | seen_q | (wait_q != 2'h0);
  wire        idle_w   = (gap_q != 16'h0000) && (gcnt_q == gap_q) && data_w;
  wire        push_v   = flush_w | (rx_valid_i & ~hold_w) |
                         (~rx_valid_i & idle_w);
  wire        push_f   = push_v & fifo_rdy;
  wire        step_w   = fifo_rdy & (push_v | hold_w);
  wire        take_w   = rx_valid_i & ~flush_w & fifo_rdy;

  assign rx_ready_o = fifo_rdy & ~flush_w;

  // Build the word; flush beats a new byte, a byte beats idle.
  always_comb begin
    word_d = '0;
    seen_d = seen_q;
    wait_d = wait_q;
    if (flush_w) begin
      word_d.keep = 1'b1;
      word_d.data = dlm_q.d1;
      word_d.last = cap_w;
      seen_d      = 1'b0;
    end else if (rx_valid_i) begin
      word_d.data = rx_data_i;
      if (wait_q != 2'h0) begin
        // Trailing bytes after a delimiter go in unexamined.
        word_d.keep = 1'b1;
        word_d.last = (wait_q == 2'h1) | cap_w;
        wait_d      = wait_q - 2'h1;
      end else if (match_w) begin
        seen_d = 1'b0;
        case (proc_q)
          PROC_STRIP: begin
            word_d.last = 1'b1;
          end
          PROC_PLUS1: begin
            word_d.keep = 1'b1;
            word_d.last = cap_w;
            wait_d      = 2'h1;
          end
          PROC_PLUS2: begin
            word_d.keep = 1'b1;
            word_d.last = cap_w;
            wait_d      = 2'h2;
          end
          default: begin
            word_d.keep = 1'b1;
            word_d.last = 1'b1;
          end
        endcase
      end else begin
        // Ordinary byte, or the held first of a pair.
        word_d.keep = ~hold_w;
        word_d.last = cap_w & ~hold_w;
        seen_d      = pair_w & (rx_data_i == dlm_q.d1);
      end
    end else if (idle_w) begin
      // A held first character is sent, else an empty end marker.
      word_d.keep = strip_w & seen_q;
      word_d.data = dlm_q.d1;
      word_d.last = 1'b1;
    end
  end

  // Packet state; any end restarts an empty packet.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q  <= 11'h000;
      seen_q <= 1'b0;
      wait_q <= 2'h0;
    end else if (step_w) begin
      if (word_d.last) begin
        cnt_q  <= 11'h000;
        seen_q <= 1'b0;
        wait_q <= 2'h0;
      end else begin
        cnt_q  <= cnt_q + {10'h000, word_d.keep};
        seen_q <= seen_d;
        wait_q <= wait_d;
      end
    end
  end

  // Millisecond enable, restarted by every accepted byte.
  spdp_tick #(
    .DIV    (MS_CYCLES)
  ) u_tick (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .clr_i  (take_w),
    .tick_o (ms_tick)
  );

  // Gap counter saturates at the setting so the trigger holds.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gcnt_q <= 16'h0000;
    end else if (take_w) begin
      gcnt_q <= 16'h0000;
    end else if (ms_tick && gcnt_q < gap_q) begin
      gcnt_q <= gcnt_q + 16'h0001;
    end
  end

  // ==========================================================
  // Output buffer; a halted host set stalls draining.
  logic       fifo_ov;
  spdp_word_t fifo_w;
  spdp_fifo #(
    .WIDTH       ($bits(spdp_word_t)),
    .DEPTH       (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (push_v),
    .in_ready_o  (fifo_rdy),
    .in_data_i   (word_d),
    .out_valid_o (fifo_ov),
    .out_ready_i (pkt_ready_i & ~halt_w),
    .out_data_o  (fifo_w)
  );
  assign pkt_valid_o = fifo_ov & ~halt_w;
  assign pkt_word_o  = fifo_w;

  // ==========================================================
  // Register reads, valid only in the cycle after the strobe.
  wire [31:0] stat_w = ({21'h0, cnt_q} << SPDP_CNT_LSB) |
                       ({31'h0, halt_w} << SPDP_HALT_BIT) |
                       ({28'h0, act_q} << SPDP_ACT_LSB);
  wire [31:0] rmux_w =
    (reg_addr_i == SPDP_OFF_CONN) ? {26'h0, drv_q, byp_q, 1'b0, max_q} :
    (reg_addr_i == SPDP_OFF_LEN)  ? {21'h0, len_q} :
    (reg_addr_i == SPDP_OFF_DLM)  ? {10'h0, proc_q, 2'h0, dlm_q} :
    (reg_addr_i == SPDP_OFF_GAP)  ? {16'h0, gap_q} :
    (reg_addr_i == SPDP_OFF_STAT) ? stat_w : 32'h0;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_rd_i ? rmux_w : 32'h0;
    end
  end
  assign reg_rdata_o = rdata_q;

  // ==========================================================
  // Checks.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_pair_hit;
    take_w && pair_w && seen_q && wait_q == 2'h0 && rx_data_i == dlm_q.d2;
  endsequence
  sequence s_restart; cnt_q == 11'h000 && !seen_q && wait_q == 2'h0; endsequence
  property p_conn_max; conn_grant_o |-> $countones(act_q) <= max_q; endproperty
  property p_bypass; byp_q |-> tx_en_o == (act_q & ~host_jam_i); endproperty
  property p_halt;
    !byp_q && (act_q & host_jam_i) != 4'h0 |-> tx_en_o == 4'h0 && !pkt_valid_o;
  endproperty
  property p_drv; drv_cmd_i && max_q > 3'h1 && !drv_q |=> !drv_ack_o; endproperty
  property p_len;
    push_f && word_d.keep && len_q != 11'h000 && cinc_w == len_q |=> s_restart;
  endproperty
  property p_pair;
    s_pair_hit ##0 proc_q == PROC_NONE |-> push_f && word_d.last && word_d.keep;
  endproperty
  property p_full; cnt_q < BUF_BYTES; endproperty
  property p_strip;
    push_f && word_d.keep && strip_w && single_w && wait_q == 2'h0
      |-> word_d.data != dlm_q.d1;
  endproperty
  property p_gap; push_f && !rx_valid_i |-> gap_q != 16'h0000 && gcnt_q == gap_q; endproperty
  property p_restart; push_f && word_d.last |=> s_restart; endproperty
  a_conn_max: assert property (p_conn_max) else $error("host limit exceeded");
  a_bypass: assert property (p_bypass) else $error("bypass gating wrong");
  a_halt: assert property (p_halt) else $error("send during jam");
  a_drv: assert property (p_drv) else $error("driver command not gated");
  a_len: assert property (p_len) else $error("length trigger missed");
  a_pair: assert property (p_pair) else $error("pair did not pack");
  a_full: assert property (p_full) else $error("buffer overran");
  a_strip: assert property (p_strip) else $error("delimiter not stripped");
  a_gap: assert property (p_gap) else $error("idle pack too early");
  a_restart: assert property (p_restart) else $error("packet not restarted");
endmodule

// ### common/spdp_pkg.sv
package spdp_pkg;
  // ==========================================================
  // Register offsets and field positions.
  localparam logic [4:0] SPDP_OFF_CONN  = 5'h00;
  localparam logic [4:0] SPDP_OFF_LEN   = 5'h04;
  localparam logic [4:0] SPDP_OFF_DLM   = 5'h08;
  localparam logic [4:0] SPDP_OFF_GAP   = 5'h0c;
  localparam logic [4:0] SPDP_OFF_STAT  = 5'h10;
  localparam int         SPDP_MAX_LSB   = 0;
  localparam int         SPDP_BYP_BIT   = 4;
  localparam int         SPDP_DRV_BIT   = 5;
  localparam int         SPDP_DLM_LSB   = 0;
  localparam int         SPDP_PROC_LSB  = 20;
  localparam int         SPDP_ACT_LSB   = 0;
  localparam int         SPDP_HALT_BIT  = 4;
  localparam int         SPDP_CNT_LSB   = 8;
  // ==========================================================
  // Reset values and limits.
  localparam logic [2:0]  SPDP_MAX_RST  = 3'h1;
  localparam logic [2:0]  SPDP_MAX_TOP  = 3'h4;
  localparam logic        SPDP_BYP_RST  = 1'h0;
  localparam logic        SPDP_DRV_RST  = 1'h0;
  localparam logic [10:0] SPDP_LEN_RST  = 11'h000;
  localparam logic [10:0] SPDP_LEN_TOP  = 11'h400;
  localparam logic [15:0] SPDP_GAP_RST  = 16'h0000;
  localparam logic [10:0] SPDP_BUF_RST  = 11'h400;
  localparam int          SPDP_HOSTS    = 4;
  localparam int          SPDP_FIFO_DEP = 16;
  // ==========================================================
  // Timing: the idle gap counts in milliseconds.
  localparam int SPDP_CLK_PERIOD_NS = 20;
  localparam int SPDP_GAP_UNIT_NS   = 1000000;
  localparam int SPDP_MS_CYCLES     = SPDP_GAP_UNIT_NS / SPDP_CLK_PERIOD_NS;
  // ==========================================================
  // Types.
  typedef enum logic [1:0] {
    PROC_NONE,
    PROC_PLUS1,
    PROC_PLUS2,
    PROC_STRIP
  } spdp_proc_t;
  // Two delimiter characters with their enables.
  typedef struct packed {
    logic       en2;
    logic       en1;
    logic [7:0] d2;
    logic [7:0] d1;
  } spdp_dlm_t;
  // One buffered word; keep low marks an empty end marker.
  typedef struct packed {
    logic       last;
    logic       keep;
    logic [7:0] data;
  } spdp_word_t;
  localparam spdp_dlm_t SPDP_DLM_RST = 18'h00000;
endpackage

// ### rtl/spdp_tick.sv
`timescale 1ns/1ps
// Millisecond enable divider, restarted by clr_i.
module spdp_tick #(
  parameter int unsigned DIV = 50000
) (
  // Clock and reset.
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  // Control.
  input  wire logic clr_i,
  output logic      tick_o
);
  // ==========================================================
  // Divider counter.
  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] TOP = CW'(DIV - 1);
  logic [CW-1:0] cnt_q;   // Cycles into the current millisecond.
  wire           wrap_w = (cnt_q == TOP);
  // Restarting on clear makes each gap start at a byte edge.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
    end else if (clr_i || wrap_w) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end
  assign tick_o = wrap_w & ~clr_i;
endmodule

// ### rtl/spdp_fifo.sv
`timescale 1ns/1ps
// Word FIFO with valid and ready on both sides.
module spdp_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             mclk_i,
  input  wire logic             rstn_i,
  // Fill side.
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  // ==========================================================
  // Storage and pointers.
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] PTOP = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];   // Word store.
  logic [AW-1:0]    wr_q;            // Next write slot.
  logic [AW-1:0]    rd_q;            // Oldest word.
  logic [CW-1:0]    cnt_q;           // Words held.
  wire wr_w = in_valid_i & in_ready_o;
  wire rd_w = out_valid_o & out_ready_i;
  assign in_ready_o  = (cnt_q != FULL);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  // Store written words; the array needs no reset.
  always_ff @(posedge mclk_i) begin
    if (wr_w) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (wr_w) begin
        wr_q <= (wr_q == PTOP) ? '0 : wr_q + AW'(1);
      end
      if (rd_w) begin
        rd_q <= (rd_q == PTOP) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + CW'(wr_w) - CW'(rd_w);
    end
  end
endmodule

// ### dv/spdp_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Network host model: takes packet words, promptly or with stalls.
module spdp_host_model (
  // Clock and reset.
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  // Pace select: high makes the host stall at random.
  input  wire logic slow_i,
  // Packet side.
  output logic      pkt_ready_o
);
  // Ready moves only just after an edge, so a word is never half taken.
  // A slow host is the awkward case: it back-pressures the buffer.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pkt_ready_o <= 1'b0;
    end else if (slow_i) begin
      pkt_ready_o <= 1'($urandom_range(0, 1));
    end else begin
      pkt_ready_o <= 1'b1;
    end
  end
endmodule

// ### dv/tb_serial_port_data_packer.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_serial_port_data_packer;
  import spdp_pkg::*;
  // ==========================================================
  // Signals and scoreboard.
  logic        mclk_i, rstn_i, reg_wr_i, reg_rd_i, rx_valid_i, rx_ready_o;
  logic        pkt_valid_o, pkt_ready_i, slow, conn_req_i, conn_grant_o;
  logic        conn_deny_o, drv_cmd_i, drv_ack_o;
  logic [4:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [7:0]  rx_data_i;
  logic [1:0]  conn_slot_o;
  logic [3:0]  conn_close_i, host_jam_i, tx_en_o;
  spdp_word_t  pkt_word_o, exp_w, exp_q[$];
  int          n_fail, n_checks, p, k;
  // ==========================================================
  // Design and host model; short counts keep the run brief.
  spdp_packer #(.MS_CYCLES(10), .FIFO_DEPTH(16), .BUF_BYTES(11'h014)) dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o),
    .pkt_valid_o(pkt_valid_o), .pkt_ready_i(pkt_ready_i), .pkt_word_o(pkt_word_o),
    .conn_req_i(conn_req_i), .conn_grant_o(conn_grant_o), .conn_deny_o(conn_deny_o),
    .conn_slot_o(conn_slot_o), .conn_close_i(conn_close_i), .host_jam_i(host_jam_i),
    .tx_en_o(tx_en_o), .drv_cmd_i(drv_cmd_i), .drv_ack_o(drv_ack_o));
  spdp_host_model host (.mclk_i(mclk_i), .rstn_i(rstn_i), .slow_i(slow),
    .pkt_ready_o(pkt_ready_i));
  // 50 MHz clock.
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // ==========================================================
  // Monitor: each word taken is matched to the oldest note.
  // End markers carry no data, so their data field is masked.
  always @(posedge mclk_i) begin
    if (rstn_i && pkt_valid_o && pkt_ready_i) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("mismatch pkt_word exp none got %h", pkt_word_o);
      end else begin
        exp_w = exp_q.pop_front();
        `CHK("pkt_word", exp_w, {pkt_word_o.last, pkt_word_o.keep,
          (pkt_word_o.keep ? pkt_word_o.data : 8'h00)})
      end
    end
  end
  // ==========================================================
  // Closing report; it ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic expire();
    n_fail++;
    $display("mismatch wait exp done got timeout");
    results();
  endtask
  // Register write; the extra edge keeps strobes from merging.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  // Register read; data stand only in the cycle after the strobe.
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata_o)
    @(posedge mclk_i);
  endtask
  // Connection request; exactly one of grant or deny answers.
  task automatic conn(input logic g);
    conn_req_i <= 1'b1;
    @(posedge mclk_i);
    conn_req_i <= 1'b0;
    #1 `CHK("conn_grant", g, conn_grant_o)
    `CHK("conn_deny", ~g, conn_deny_o)
    @(posedge mclk_i);
  endtask
  task automatic drv(input logic e);
    drv_cmd_i <= 1'b1;
    @(posedge mclk_i);
    drv_cmd_i <= 1'b0;
    #1 `CHK("drv_ack", e, drv_ack_o)
    @(posedge mclk_i);
  endtask
  // Offer one serial byte and hold it until taken; ready is read at
  // the falling edge so the sample never races the design's update.
  task automatic tx(input logic [7:0] d, input logic last = 1'b0, input bit push = 1);
    int  i;
    logic ok;
    if (push) exp_q.push_back('{last, 1'b1, d});
    rx_valid_i <= 1'b1;
    rx_data_i <= d;
    for (i = 0; i < 300; i++) begin
      @(negedge mclk_i);
      ok = rx_ready_o;
      @(posedge mclk_i);
      if (ok === 1'b1) break;
    end
    if (i == 300) expire();
  endtask
  task automatic rx_idle();
    rx_valid_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic drain();
    int i;
    for (i = 0; i < 600; i++) begin
      if (exp_q.size() == 0) break;
      @(posedge mclk_i);
    end
    if (exp_q.size() != 0) expire();
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    rstn_i = 1'b0; reg_addr_i = 5'h00; reg_wdata_i = 32'h0; reg_wr_i = 1'b0;
    reg_rd_i = 1'b0; rx_valid_i = 1'b0; rx_data_i = 8'h00; slow = 1'b0;
    conn_req_i = 1'b0; conn_close_i = 4'h0; host_jam_i = 4'h0; drv_cmd_i = 1'b0;
    n_fail = 0;
    n_checks = 0;
    void'($urandom(32'hf000c54f));
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    rd(SPDP_OFF_CONN, 32'h1);
    rd(SPDP_OFF_LEN, 32'h0);
    rd(SPDP_OFF_DLM, 32'h0);
    rd(SPDP_OFF_GAP, 32'h0);
    rd(SPDP_OFF_STAT, 32'h10);
    rd(5'h14, 32'h0);
    conn(1'b1);
    conn(1'b0);
    drv(1'b1);
    wr(SPDP_OFF_CONN, 32'h12);
    conn(1'b1);
    `CHK("conn_slot", 2'h1, conn_slot_o)
    conn(1'b0);
    drv(1'b0);
    wr(SPDP_OFF_CONN, 32'h32);
    drv(1'b1);
    host_jam_i <= 4'h1;
    #1 `CHK("tx_en", 4'h2, tx_en_o)
    @(posedge mclk_i);
    wr(SPDP_OFF_CONN, 32'h22);
    #1 `CHK("tx_en", 4'h0, tx_en_o)
    @(posedge mclk_i);
    // Halted output: the buffer fills until the source is refused.
    slow <= 1'b1;
    repeat (16) tx(8'($urandom));
    rx_idle();
    @(negedge mclk_i);
    `CHK("rx_ready", 1'b0, rx_ready_o)
    `CHK("pkt_valid", 1'b0, pkt_valid_o)
    @(posedge mclk_i);
    host_jam_i <= 4'h0;
    #1 `CHK("tx_en", 4'h3, tx_en_o)
    @(posedge mclk_i);
    repeat (3) tx(8'($urandom));
    tx(8'($urandom), 1'b1);
    rx_idle();
    wr(SPDP_OFF_LEN, 32'h4);
    repeat (2) begin
      repeat (3) tx(8'($urandom));
      tx(8'($urandom), 1'b1);
    end
    rx_idle();
    wr(SPDP_OFF_LEN, 32'h0);
    for (p = 0; p < 4; p++) begin
      wr(SPDP_OFF_DLM, 32'h1000d | (32'(p) << SPDP_PROC_LSB));
      tx(8'h41);
      tx(8'h0d, p == 0, p != 3);
      if (p == 3) exp_q.push_back('{1'b1, 1'b0, 8'h00});
      for (k = 1; k <= p && p < 3; k++) tx(8'(8'h30 + k), k == p);
      rx_idle();
    end
    wr(SPDP_OFF_DLM, 32'h30a0d);
    rd(SPDP_OFF_DLM, 32'h30a0d);
    tx(8'h0d);
    tx(8'h41);
    tx(8'h0d);
    tx(8'h0a, 1'b1);
    rx_idle();
    // strip a pair; a lone first character is still sent on.
    wr(SPDP_OFF_DLM, 32'h330a0d);
    tx(8'h0d);
    tx(8'h41);
    tx(8'h0d, 1'b0, 1'b0);
    tx(8'h0a, 1'b0, 1'b0);
    exp_q.push_back('{1'b1, 1'b0, 8'h00});
    rx_idle();
    wr(SPDP_OFF_DLM, 32'h0);
    wr(SPDP_OFF_GAP, 32'h1);
    tx(8'h41);
    tx(8'h42);
    rx_idle();
    exp_q.push_back('{1'b1, 1'b0, 8'h00});
    drain();
    wr(SPDP_OFF_GAP, 32'h0);
    conn_close_i <= 4'h2;
    @(posedge mclk_i);
    conn_close_i <= 4'h0;
    @(posedge mclk_i);
    conn(1'b1);
    `CHK("conn_slot", 2'h1, conn_slot_o)
    drain();
    results();
  end
endmodule
